/* File: rtl/bacd_axil_slave.sv */
// AXI4-Lite slave front end with a simple register strobe port
`timescale 1ns/1ns
`default_nettype none
module bacd_axil_slave (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [bacd_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [bacd_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [bacd_pkg::AXI_AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [bacd_pkg::AXI_AW-1:0] rd_addr,
  input wire logic [31:0] rd_data
);
  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic awready;
    logic wready;
    logic arready;
    logic [bacd_pkg::AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic wr_en;
    logic rd_pend;
    logic [bacd_pkg::AXI_AW-1:0] araddr;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } bacd_axil_type;

  bacd_axil_type s;
  bacd_axil_type next_s;

  always_comb begin
    next_s = s;
    next_s.wr_en = 1'b0;
    if (awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.wr_en = 1'b1;
      next_s.bvalid = 1'b1;
      next_s.bresp = bacd_pkg::reg_mapped(s.awaddr) ?
        bacd_pkg::RESP_OKAY : bacd_pkg::RESP_SLVERR;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      next_s.rd_pend = 1'b1;
      next_s.araddr = araddr;
    end
    if (s.rd_pend) begin
      next_s.rd_pend = 1'b0;
      next_s.rvalid = 1'b1;
      if (bacd_pkg::reg_mapped(s.araddr)) begin
        next_s.rdata = rd_data;
        next_s.rresp = bacd_pkg::RESP_OKAY;
      end else begin
        next_s.rdata = 32'h0000_0000;
        next_s.rresp = bacd_pkg::RESP_SLVERR;
      end
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    // One write and one read in flight at most
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rd_pend && !next_s.rvalid;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign wr_en = s.wr_en;
  assign wr_addr = s.awaddr;
  assign wr_data = s.wdata;
  assign wr_strb = s.wstrb;
  assign rd_addr = s.araddr;
endmodule : bacd_axil_slave
`default_nettype wire

/* File: rtl/bacd_decoder.sv */
// Bit test, skip and control operation decoder with register access
// Notes on behaviour
// - Nibble 1011 skips if bit clear; 1 cycle, 2 or 3 when skipping.
// - Nibble 1010 skips if bit set; same fields and cycle costs.
// - Prefix 1110 0111 branches when negative clear; 1 or 2 cycles.
// - Prefix 1110 0101 branches when overflow clear; all 1110 0ccc branch.
// - Absolute jump and call take two words; second word is 1111 plus 12.
// - Word 0x0006 pops the return stack in one cycle.
// - Word 0x0005 pushes the return address in one cycle.
// - 0000 0000 0001 000s returns from interrupt, sets both enables.
// - Prefix 0000 1100 returns with literal into working register.
// - Word 0x0003 enters standby and updates timeout and power flags.
// - Taken tests and program counter changes add no-op cycles; two for a skip over a two-word instruction.
// - A lone second word executes as a no-op.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module bacd_decoder (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [bacd_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bacd_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic test_bit,
  input wire logic next_two_word,
  input wire logic flag_z,
  input wire logic flag_c,
  input wire logic flag_ov,
  input wire logic flag_n,
  output logic dec_valid,
  output bacd_pkg::bacd_op_type dec_op,
  output logic [2:0] bit_index,
  output logic access_bank,
  output logic [7:0] file_addr,
  output logic [7:0] literal,
  output logic [bacd_pkg::TGT_W-1:0] target,
  output logic fast_restore,
  output logic branch_taken,
  output logic insert_nop,
  output logic [1:0] cycles,
  output logic global_interrupt_enable,
  output logic peripheral_interrupt_enable,
  output logic watchdog_expired_flag,
  output logic power_down_flag
);
  typedef struct packed {
    logic en;
    logic gie;
    logic peie;
    logic wdt_to;
    logic pd;
    logic pend;
    logic [7:0] tgt_lo;
    logic valid;
    bacd_pkg::bacd_op_type op;
    logic [2:0] bit_idx;
    logic acc;
    logic [7:0] faddr;
    logic [7:0] lit;
    logic [bacd_pkg::TGT_W-1:0] tgt;
    logic fast;
    logic taken;
    logic nop;
    logic [1:0] cyc;
    logic [15:0] count;
  } bacd_state_type;

  bacd_state_type s;
  bacd_state_type next_s;
  bacd_pkg::bacd_op_type raw_op;
  logic wr_en;
  logic [bacd_pkg::AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [bacd_pkg::AXI_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic cond_ok;
  logic go;

  bacd_axil_slave u_axil (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  bacd_op_classify u_cls (
    .word(instr_word),
    .op(raw_op)
  );

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      bacd_pkg::REG_CTRL: rd_data[bacd_pkg::CTRL_EN] = s.en;
      bacd_pkg::REG_STATUS: begin
        rd_data[bacd_pkg::ST_GIE] = s.gie;
        rd_data[bacd_pkg::ST_PEIE] = s.peie;
        rd_data[bacd_pkg::ST_TO] = s.wdt_to;
        rd_data[bacd_pkg::ST_PD] = s.pd;
        rd_data[bacd_pkg::ST_PEND] = s.pend;
      end
      bacd_pkg::REG_COUNT: rd_data[15:0] = s.count;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Branch condition from the low three bits of the prefix byte
  always_comb begin
    unique case (instr_word[bacd_pkg::COND_HI:bacd_pkg::COND_LO])
      bacd_pkg::COND_Z: cond_ok = flag_z;
      bacd_pkg::COND_NZ: cond_ok = !flag_z;
      bacd_pkg::COND_C: cond_ok = flag_c;
      bacd_pkg::COND_NC: cond_ok = !flag_c;
      bacd_pkg::COND_OV: cond_ok = flag_ov;
      bacd_pkg::COND_NOV: cond_ok = !flag_ov;
      bacd_pkg::COND_N: cond_ok = flag_n;
      default: cond_ok = !flag_n;
    endcase
  end

  assign go = instr_valid && s.en;

  always_comb begin
    next_s = s;
    next_s.valid = 1'b0;
    // Software writes: clear requests lose to same-cycle hardware sets
    if (wr_en && wr_strb[0]) begin
      if (wr_addr == bacd_pkg::REG_CTRL) begin
        next_s.en = wr_data[bacd_pkg::CTRL_EN];
      end
      if (wr_addr == bacd_pkg::REG_CLEAR) begin
        if (wr_data[bacd_pkg::CLR_GIE]) next_s.gie = 1'b0;
        if (wr_data[bacd_pkg::CLR_PEIE]) next_s.peie = 1'b0;
        if (wr_data[bacd_pkg::CLR_FLAGS]) begin
          next_s.wdt_to = bacd_pkg::TO_RST;
          next_s.pd = bacd_pkg::PD_RST;
        end
      end
    end
    if (go) begin
      next_s.valid = 1'b1;
      next_s.count = s.count + 16'h0001;
      next_s.op = raw_op;
      next_s.bit_idx = instr_word[bacd_pkg::BIT_HI:bacd_pkg::BIT_LO];
      next_s.acc = instr_word[bacd_pkg::ACC_POS];
      next_s.faddr = instr_word[bacd_pkg::BYTE_HI:0];
      next_s.lit = instr_word[bacd_pkg::BYTE_HI:0];
      next_s.fast = instr_word[bacd_pkg::FAST_POS];
      next_s.taken = 1'b0;
      next_s.cyc = bacd_pkg::CYC_ONE;
      next_s.pend = 1'b0;
      if (s.pend && instr_word[bacd_pkg::NIB_HI:bacd_pkg::NIB_LO] ==
          bacd_pkg::NIB_SECOND) begin
        next_s.op = bacd_pkg::OP_TARGET;
        next_s.tgt = {instr_word[bacd_pkg::SEC_HI:0], s.tgt_lo};
        next_s.cyc = bacd_pkg::CYC_TWO;
      end else begin
        unique case (raw_op)
          bacd_pkg::OP_SKIP_CLR, bacd_pkg::OP_SKIP_SET: begin
            next_s.taken = (raw_op == bacd_pkg::OP_SKIP_SET) ?
              test_bit : !test_bit;
            if (next_s.taken) begin
              next_s.cyc = next_two_word ?
                bacd_pkg::CYC_THREE : bacd_pkg::CYC_TWO;
            end
          end
          bacd_pkg::OP_BRANCH: begin
            next_s.taken = cond_ok;
            next_s.cyc = cond_ok ? bacd_pkg::CYC_TWO : bacd_pkg::CYC_ONE;
          end
          bacd_pkg::OP_JUMP, bacd_pkg::OP_CALL: begin
            next_s.pend = 1'b1;
            next_s.tgt_lo = instr_word[bacd_pkg::BYTE_HI:0];
            next_s.fast = instr_word[bacd_pkg::CALL_FAST_POS];
            next_s.cyc = bacd_pkg::CYC_TWO;
          end
          bacd_pkg::OP_RETURN_FROM_INTERRUPT: begin
            next_s.gie = 1'b1;
            next_s.peie = 1'b1;
            next_s.cyc = bacd_pkg::CYC_TWO;
          end
          bacd_pkg::OP_RETURN_LITERAL: next_s.cyc = bacd_pkg::CYC_TWO;
          bacd_pkg::OP_STANDBY: begin
            next_s.wdt_to = bacd_pkg::STBY_TO;
            next_s.pd = bacd_pkg::STBY_PD;
          end
          // Single-cycle ops: pop, push, bit ops, lone second word
          default: next_s.cyc = bacd_pkg::CYC_ONE;
        endcase
      end
      // Every extra cycle beyond the first runs as a no-op
      next_s.nop = next_s.cyc != bacd_pkg::CYC_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s <= '0;
      s.en <= bacd_pkg::CTRL_EN_RST;
      s.wdt_to <= bacd_pkg::TO_RST;
      s.pd <= bacd_pkg::PD_RST;
      s.op <= bacd_pkg::OP_NOP;
      s.cyc <= bacd_pkg::CYC_ONE;
    end else begin
      s <= next_s;
    end
  end

  assign dec_valid = s.valid;
  assign dec_op = s.op;
  assign bit_index = s.bit_idx;
  assign access_bank = s.acc;
  assign file_addr = s.faddr;
  assign literal = s.lit;
  assign target = s.tgt;
  assign fast_restore = s.fast;
  assign branch_taken = s.taken;
  assign insert_nop = s.nop;
  assign cycles = s.cyc;
  assign global_interrupt_enable = s.gie;
  assign peripheral_interrupt_enable = s.peie;
  assign watchdog_expired_flag = s.wdt_to;
  assign power_down_flag = s.pd;

  logic [15:0] prev_word;
  always_ff @(posedge sys_clk) begin
    prev_word <= instr_word;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence jump_first_s;
    go && !s.pend && instr_word[15:8] == bacd_pkg::BYTE_JUMP;
  endsequence
  sequence second_word_s;
    go && instr_word[15:12] == bacd_pkg::NIB_SECOND;
  endsequence

  skip_clear_a: assert property (
    go && !s.pend && instr_word[15:12] == bacd_pkg::NIB_SKIP_CLR &&
    !test_bit && next_two_word |=> s.op == bacd_pkg::OP_SKIP_CLR &&
    s.cyc == bacd_pkg::CYC_THREE && s.nop && s.taken)
    else $error("skip on clear bit wrong");
  skip_set_a: assert property (
    go && !s.pend && instr_word[15:12] == bacd_pkg::NIB_SKIP_SET &&
    !test_bit |=> s.cyc == bacd_pkg::CYC_ONE && !s.taken && !s.nop)
    else $error("skip on set bit wrong");
  branch_nn_a: assert property (
    go && !s.pend && instr_word[15:8] == 8'he7 && !flag_n
    |=> s.taken && s.cyc == bacd_pkg::CYC_TWO)
    else $error("branch not negative wrong");
  branch_nov_a: assert property (
    go && !s.pend && instr_word[15:8] == 8'he5 && flag_ov
    |=> !s.taken && s.cyc == bacd_pkg::CYC_ONE)
    else $error("branch no overflow wrong");
  jump_pair_a: assert property (
    jump_first_s ##1 second_word_s |=> s.op == bacd_pkg::OP_TARGET &&
    s.tgt[7:0] == $past(s.tgt_lo) && s.tgt[19:8] == prev_word[11:0])
    else $error("two word jump target wrong");
  lone_second_a: assert property (
    go && !s.pend && instr_word[15:12] == bacd_pkg::NIB_SECOND
    |=> s.op == bacd_pkg::OP_NOP && s.cyc == bacd_pkg::CYC_ONE)
    else $error("lone second word not a no-op");
  stack_ops_a: assert property (
    go && !s.pend && !wr_en && (instr_word == bacd_pkg::W_POP ||
    instr_word == bacd_pkg::W_PUSH) |=> s.cyc == bacd_pkg::CYC_ONE &&
    $stable(s.gie) && $stable(s.pd))
    else $error("stack op wrong");
  return_int_a: assert property (
    go && !s.pend && instr_word[15:1] == bacd_pkg::RETURN_FROM_INTERRUPT_PFX
    |=> s.gie && s.peie && s.cyc == bacd_pkg::CYC_TWO)
    else $error("return from interrupt wrong");
  return_lit_a: assert property (
    go && !s.pend && instr_word[15:8] == bacd_pkg::BYTE_RETURN_LITERAL
    |=> s.op == bacd_pkg::OP_RETURN_LITERAL && s.lit == prev_word[7:0])
    else $error("return literal wrong");
  standby_a: assert property (
    go && !s.pend && instr_word == bacd_pkg::W_STANDBY
    |=> s.pd == bacd_pkg::STBY_PD && s.wdt_to == bacd_pkg::STBY_TO)
    else $error("standby flags wrong");
  bit_op_a: assert property (
    go && !s.pend && instr_word[15:12] == bacd_pkg::NIB_BIT_INV
    |=> s.op == bacd_pkg::OP_BIT_INV && s.cyc == bacd_pkg::CYC_ONE &&
    s.bit_idx == prev_word[11:9])
    else $error("bit op wrong");
  undefined_a: assert property (
    go && !s.pend && !wr_en && instr_word == 16'h0007 |=> s.op ==
    bacd_pkg::OP_NOP && !s.nop && $stable(s.peie) && $stable(s.wdt_to))
    else $error("undefined word had effect");
endmodule : bacd_decoder
`default_nettype wire

/* File: rtl/bacd_op_classify.sv */
// Opcode pattern matcher for one instruction word
`timescale 1ns/1ns
`default_nettype none
module bacd_op_classify (
  input wire logic [15:0] word,
  output bacd_pkg::bacd_op_type op
);
  logic [3:0] nib;

  always_comb begin
    nib = word[bacd_pkg::NIB_HI:bacd_pkg::NIB_LO];
    op = bacd_pkg::OP_NOP;
    if (nib == bacd_pkg::NIB_SKIP_CLR) begin
      op = bacd_pkg::OP_SKIP_CLR;
    end else if (nib == bacd_pkg::NIB_SKIP_SET) begin
      op = bacd_pkg::OP_SKIP_SET;
    end else if (nib == bacd_pkg::NIB_BIT_CLR) begin
      op = bacd_pkg::OP_BIT_CLR;
    end else if (nib == bacd_pkg::NIB_BIT_SET) begin
      op = bacd_pkg::OP_BIT_SET;
    end else if (nib == bacd_pkg::NIB_BIT_INV) begin
      op = bacd_pkg::OP_BIT_INV;
    end else if (word[15:11] == bacd_pkg::BR_PFX) begin
      op = bacd_pkg::OP_BRANCH;
    end else if (word[15:8] == bacd_pkg::BYTE_JUMP) begin
      op = bacd_pkg::OP_JUMP;
    end else if (word[15:9] == bacd_pkg::CALL_PFX) begin
      op = bacd_pkg::OP_CALL;
    end else if (word[15:8] == bacd_pkg::BYTE_RETURN_LITERAL) begin
      op = bacd_pkg::OP_RETURN_LITERAL;
    end else if (word[15:1] == bacd_pkg::RETURN_FROM_INTERRUPT_PFX) begin
      op = bacd_pkg::OP_RETURN_FROM_INTERRUPT;
    end else if (word == bacd_pkg::W_POP) begin
      op = bacd_pkg::OP_POP;
    end else if (word == bacd_pkg::W_PUSH) begin
      op = bacd_pkg::OP_PUSH;
    end else if (word == bacd_pkg::W_STANDBY) begin
      op = bacd_pkg::OP_STANDBY;
    end
  end
endmodule : bacd_op_classify
`default_nettype wire

/* File: rtl/bacd_pkg.sv */
// Shared constants and types for the bit and control operation decoder
package bacd_pkg;
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned TGT_W = 20;

  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] REG_CLEAR = 8'h08;
  localparam logic [AXI_AW-1:0] REG_COUNT = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned ST_GIE = 0;
  localparam int unsigned ST_PEIE = 1;
  localparam int unsigned ST_TO = 2;
  localparam int unsigned ST_PD = 3;
  localparam int unsigned ST_PEND = 4;
  localparam int unsigned CLR_GIE = 0;
  localparam int unsigned CLR_PEIE = 1;
  localparam int unsigned CLR_FLAGS = 2;

  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;
  localparam logic STBY_TO = 1'b1;
  localparam logic STBY_PD = 1'b0;

  // Instruction word fields
  localparam int unsigned NIB_HI = 15;
  localparam int unsigned NIB_LO = 12;
  localparam int unsigned BIT_HI = 11;
  localparam int unsigned BIT_LO = 9;
  localparam int unsigned ACC_POS = 8;
  localparam int unsigned BYTE_HI = 7;
  localparam int unsigned COND_HI = 10;
  localparam int unsigned COND_LO = 8;
  localparam int unsigned FAST_POS = 0;
  localparam int unsigned CALL_FAST_POS = 8;
  localparam int unsigned SEC_HI = 11;

  localparam logic [3:0] NIB_SKIP_CLR = 4'hb;
  localparam logic [3:0] NIB_SKIP_SET = 4'ha;
  localparam logic [3:0] NIB_BIT_CLR = 4'h9;
  localparam logic [3:0] NIB_BIT_SET = 4'h8;
  localparam logic [3:0] NIB_BIT_INV = 4'h7;
  localparam logic [3:0] NIB_SECOND = 4'hf;
  localparam logic [4:0] BR_PFX = 5'h1c;
  localparam logic [7:0] BYTE_JUMP = 8'hef;
  localparam logic [6:0] CALL_PFX = 7'h76;
  localparam logic [7:0] BYTE_RETURN_LITERAL = 8'h0c;
  localparam logic [14:0] RETURN_FROM_INTERRUPT_PFX = 15'h0008;
  localparam logic [15:0] W_POP = 16'h0006;
  localparam logic [15:0] W_PUSH = 16'h0005;
  localparam logic [15:0] W_STANDBY = 16'h0003;

  localparam logic [2:0] COND_Z = 3'h0;
  localparam logic [2:0] COND_NZ = 3'h1;
  localparam logic [2:0] COND_C = 3'h2;
  localparam logic [2:0] COND_NC = 3'h3;
  localparam logic [2:0] COND_OV = 3'h4;
  localparam logic [2:0] COND_NOV = 3'h5;
  localparam logic [2:0] COND_N = 3'h6;

  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic [3:0] {
    OP_NOP, OP_BIT_CLR, OP_BIT_SET, OP_BIT_INV, OP_SKIP_CLR,
    OP_SKIP_SET, OP_BRANCH, OP_JUMP, OP_CALL, OP_TARGET, OP_POP,
    OP_PUSH, OP_RETURN_FROM_INTERRUPT, OP_RETURN_LITERAL, OP_STANDBY
  } bacd_op_type;

  function automatic logic reg_mapped(input logic [AXI_AW-1:0] a);
    return a == REG_CTRL || a == REG_STATUS || a == REG_CLEAR ||
      a == REG_COUNT;
  endfunction : reg_mapped
endpackage : bacd_pkg

/* File: verification/bacd_prog_mem.sv */
// Program memory model that hands instruction words to the decoder
`timescale 1ns/1ns
`default_nettype none
module bacd_prog_mem (
  input wire logic sys_clk,
  input wire logic fetch,
  input wire logic [4:0] addr,
  output logic instr_valid,
  output logic [15:0] instr_word
);
  logic [15:0] rom [16] = '{16'hb5a3, 16'ha5a3, 16'hef12, 16'hf345,
    16'h0006, 16'h0005, 16'h0011, 16'h0c7e, 16'h0003, 16'hf0aa,
    16'h9e55, 16'h8000, 16'h7fff, 16'h0007, 16'hed34, 16'hfabc};
  initial instr_valid = 1'b0;
  initial instr_word = 16'h0000;
  // Idle word flips each cycle so a stale word is never reused
  always @(posedge sys_clk) begin
    instr_valid <= fetch;
    if (!fetch) instr_word <= ~instr_word;
    else if (addr[4]) instr_word <= {5'h1c, addr[2:0], 8'h10};
    else instr_word <= rom[addr[3:0]];
  end
endmodule : bacd_prog_mem
`default_nettype wire

/* File: verification/test_bit_and_control_op_decoder.sv */
// Self-checking bench for the bit and control operation decoder
`timescale 1ns/1ns
`default_nettype none
module test_bit_and_control_op_decoder;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic fetch = 0, test_bit = 0, next_two_word = 0, en = 1;
  logic flag_z = 0, flag_c = 0, flag_ov = 0, flag_n = 0;
  logic [4:0] addr = 5'h00;
  logic awready, wready, bvalid, arready, rvalid, instr_valid, dec_valid;
  logic access_bank, fast_restore, branch_taken, insert_nop, gie, peie;
  logic wdf, pdf;
  logic [1:0] bresp, rresp, cycles, br, rr;
  logic [15:0] instr_word;
  logic [2:0] bit_index;
  logic [7:0] file_addr, literal;
  logic [19:0] target;
  bacd_pkg::bacd_op_type dec_op;
  int mismatches = 0, n_compared = 0, exp_count = 0;

  bacd_prog_mem bacd_prog_mem_i (.sys_clk, .fetch, .addr, .instr_valid,
    .instr_word);
  bacd_decoder bacd_decoder_i (.sys_clk, .sys_rst, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .instr_valid, .instr_word, .test_bit,
    .next_two_word, .flag_z, .flag_c, .flag_ov, .flag_n, .dec_valid,
    .dec_op, .bit_index, .access_bank, .file_addr, .literal, .target,
    .fast_restore, .branch_taken, .insert_nop, .cycles,
    .global_interrupt_enable(gie), .peripheral_interrupt_enable(peie),
    .watchdog_expired_flag(wdf), .power_down_flag(pdf));

  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
      br = bresp;
    end while (!bvalid);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
      rv = rdata;
      rr = rresp;
    end while (!rvalid);
  endtask : rd

  // Control bits: test_bit, next_two_word, z, c, ov, n
  task automatic issue(input logic [4:0] a, input int n, input logic [5:0] c);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      {test_bit, next_two_word, flag_z, flag_c, flag_ov, flag_n} <= c;
      fetch <= 1'b1;
      addr <= a + 5'(i);
    end
    @(posedge sys_clk);
    fetch <= 1'b0;
    @(posedge sys_clk);
    #1;
    if (en) exp_count += n;
  endtask : issue

  task automatic dchk(input bacd_pkg::bacd_op_type op, input logic [1:0] cy);
    chk("dec_valid", 1, dec_valid);
    chk("dec_op", op, dec_op);
    chk("cycles", cy, cycles);
    chk("insert_nop", cy > 1, insert_nop);
  endtask : dchk

  task automatic t_reset();
    rd(8'h04);
    chk("status", 32'hc, rv);
    chk("dec_op", bacd_pkg::OP_NOP, dec_op);
    chk("flags", 2'h3, {wdf, pdf});
  endtask : t_reset

  task automatic t_skip();
    issue(0, 1, 6'h10);
    dchk(bacd_pkg::OP_SKIP_CLR, 2'h3);
    chk("taken", 1, branch_taken);
    chk("fields", 12'h5a3, {bit_index, access_bank, file_addr});
    issue(1, 1, 6'h10);
    dchk(bacd_pkg::OP_SKIP_SET, 2'h1);
    chk("taken", 0, branch_taken);
    issue(1, 1, 6'h20);
    dchk(bacd_pkg::OP_SKIP_SET, 2'h2);
  endtask : t_skip

  task automatic t_branch();
    for (int c = 0; c < 8; c++) begin
      issue(5'(16 + c), 1, 6'h00);
      dchk(bacd_pkg::OP_BRANCH, c[0] ? 2'h2 : 2'h1);
      chk("taken", c[0], branch_taken);
    end
    chk("offset", 8'h10, literal);
    issue(23, 1, 6'h01);
    dchk(bacd_pkg::OP_BRANCH, 2'h1);
    issue(21, 1, 6'h02);
    dchk(bacd_pkg::OP_BRANCH, 2'h1);
  endtask : t_branch

  task automatic t_jump();
    issue(2, 2, 6'h00);
    dchk(bacd_pkg::OP_TARGET, 2'h2);
    chk("target", 20'h34512, target);
    issue(9, 1, 6'h00);
    dchk(bacd_pkg::OP_NOP, 2'h1);
    chk("target", 20'h34512, target);
    issue(14, 1, 6'h00);
    dchk(bacd_pkg::OP_CALL, 2'h2);
    chk("fast", 1, fast_restore);
    rd(8'h04);
    chk("status", 32'h1c, rv);
    issue(15, 1, 6'h00);
    dchk(bacd_pkg::OP_TARGET, 2'h2);
    chk("target", 20'habc34, target);
  endtask : t_jump

  task automatic t_control();
    issue(4, 1, 6'h00);
    dchk(bacd_pkg::OP_POP, 2'h1);
    issue(5, 1, 6'h00);
    dchk(bacd_pkg::OP_PUSH, 2'h1);
    rd(8'h04);
    chk("status", 32'hc, rv);
    issue(6, 1, 6'h00);
    dchk(bacd_pkg::OP_RETURN_FROM_INTERRUPT, 2'h2);
    chk("enables", 3'h7, {fast_restore, gie, peie});
    wr(8'h08, 32'h3);
    rd(8'h04);
    chk("status", 32'hc, rv);
    issue(7, 1, 6'h00);
    dchk(bacd_pkg::OP_RETURN_LITERAL, 2'h2);
    chk("literal", 8'h7e, literal);
    issue(8, 1, 6'h00);
    dchk(bacd_pkg::OP_STANDBY, 2'h1);
    rd(8'h04);
    chk("status", 32'h4, rv);
    chk("flags", 2'h2, {wdf, pdf});
    wr(8'h08, 32'h4);
    rd(8'h04);
    chk("status", 32'hc, rv);
    chk("flags", 2'h3, {wdf, pdf});
  endtask : t_control

  task automatic t_bitops();
    issue(10, 1, 6'h00);
    dchk(bacd_pkg::OP_BIT_CLR, 2'h1);
    chk("fields", 12'he55, {bit_index, access_bank, file_addr});
    issue(11, 1, 6'h00);
    dchk(bacd_pkg::OP_BIT_SET, 2'h1);
    issue(12, 1, 6'h00);
    dchk(bacd_pkg::OP_BIT_INV, 2'h1);
    chk("fields", 12'hfff, {bit_index, access_bank, file_addr});
    issue(13, 1, 6'h00);
    dchk(bacd_pkg::OP_NOP, 2'h1);
    rd(8'h04);
    chk("status", 32'hc, rv);
  endtask : t_bitops

  task automatic t_disable();
    wr(8'h00, 32'h0);
    en = 1'b0;
    issue(10, 1, 6'h00);
    chk("dec_valid", 0, dec_valid);
    chk("dec_op", bacd_pkg::OP_NOP, dec_op);
    rd(8'h0c);
    chk("count", 32'(exp_count), rv);
    rd(8'h10);
    chk("rresp", bacd_pkg::RESP_SLVERR, rr);
    chk("rdata", 0, rv);
    wr(8'h10, 32'h0);
    chk("bresp", bacd_pkg::RESP_SLVERR, br);
    wr(8'h00, 32'h1);
    en = 1'b1;
    rd(8'h00);
    chk("ctrl", 32'h1, rv);
  endtask : t_disable

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    #100000;
    mismatches++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_skip();
    t_branch();
    t_jump();
    t_control();
    t_bitops();
    t_disable();
    final_report();
  end
endmodule : test_bit_and_control_op_decoder
`default_nettype wire
